/* fpt_top.sv */
// Fan PWM output and tach monitor with its register port and timebases
`include "fpt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Override bit 0 of duty register forces the fan output high.
// - With override clear, duty comes from duty register bits 6 to 1.
// - Override clear and duty field zero gives a constantly low output.
// - Nonzero duty gives high fractions from 1.56% up to 98.44%.
// - Period set by duty and control registers, 0.021 to 25.5 ms, 2% tolerance.
// - High time adjustable from 0.00033 ms up to 25.1 ms.
// - Tach clock period is 30.52 us times the software divisor.
module fpt_top #(
  parameter int unsigned TACH_BASE_CYC = `FPT_TACH_BASE_CYC,
  parameter int unsigned PWM_UNIT_CYC  = `FPT_PWM_UNIT_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [`FPT_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   fan_tach_in,
  output logic                        fan_pwm_output
);

  localparam int unsigned UNIT_W = $clog2(PWM_UNIT_CYC + 1);
  localparam int unsigned BASE_W = $clog2(TACH_BASE_CYC + 1);

  // Register file
  fpt_pkg::fpt_byte_t duty_q;
  fpt_pkg::fpt_byte_t duty_d;
  fpt_pkg::fpt_byte_t ctrl_q;
  fpt_pkg::fpt_byte_t ctrl_d;
  fpt_pkg::fpt_byte_t rdata_d;

  // PWM timebase
  logic [UNIT_W-1:0] unit_cnt_q;
  logic [UNIT_W-1:0] unit_cnt_d;
  logic              unit_tick_q;
  logic              unit_tick_d;
  logic [10:0]       step_cnt_q;
  logic [10:0]       step_cnt_d;
  logic              step_tick_q;
  logic              step_tick_d;
  logic [5:0]        presc;
  logic [10:0]       step_reload;

  // Tach timebase
  logic [BASE_W-1:0] base_cnt_q;
  logic [BASE_W-1:0] base_cnt_d;
  logic [6:0]        div_cnt_q;
  logic [6:0]        div_cnt_d;
  logic [6:0]        div_last;
  logic              tach_tick_q;
  logic              tach_tick_d;

  // Tach input synchroniser
  logic [2:0]        sync_q;
  logic [2:0]        sync_d;
  logic              tach_lvl_q;
  logic              tach_lvl_d;

  // Block state seen by software
  logic [7:0]        tach_count;
  logic              tach_valid;
  logic              pwm_level;

  // Register writes land on the cycle after the strobe
  always_comb
  begin
    duty_d = duty_q;
    ctrl_d = ctrl_q;
    if (reg_wr)
    begin
      case (reg_addr)
        `FPT_OFF_DUTY: duty_d = reg_wdata;
        `FPT_OFF_CTRL: ctrl_d = reg_wdata;
        default:       ;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe; unmapped reads give zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `FPT_OFF_DUTY: rdata_d = duty_q;
        `FPT_OFF_CTRL: rdata_d = ctrl_q;
        `FPT_OFF_TACH: rdata_d = tach_count;
        `FPT_OFF_STAT:
        begin
          rdata_d[`FPT_STAT_PWM_BIT]   = pwm_level;
          rdata_d[`FPT_STAT_VALID_BIT] = tach_valid;
        end
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  // Register file and read data
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      duty_q    <= `FPT_DUTY_RST;
      ctrl_q    <= `FPT_CTRL_RST;
      reg_rdata <= 8'h00;
    end
    else
    begin
      duty_q    <= duty_d;
      ctrl_q    <= ctrl_d;
      reg_rdata <= rdata_d;
    end
  end

  assign presc = {duty_q[`FPT_DUTY_RANGE_BIT], ctrl_q[`FPT_CTRL_PRESC_MSB:`FPT_CTRL_PRESC_LSB]};
  // Zero prescale gives the fastest step; the multiplier stretches the top setting near 25 ms
  assign step_reload = (presc == 6'h00) ? 11'h001 : 11'(presc * `FPT_PWM_PRESC_MULT);

  // unit step equals shortest high time
  always_comb
  begin
    unit_cnt_d  = unit_cnt_q + {{(UNIT_W-1){1'b0}}, 1'b1};
    unit_tick_d = 1'b0;
    if (unit_cnt_q == UNIT_W'(PWM_UNIT_CYC - 1))
    begin
      unit_cnt_d  = {UNIT_W{1'b0}};
      unit_tick_d = 1'b1;
    end
  end

  // Step divider; a new prescale takes effect at the next reload, never mid-step
  always_comb
  begin
    step_cnt_d  = step_cnt_q;
    step_tick_d = 1'b0;
    if (unit_tick_q)
    begin
      if (step_cnt_q <= 11'h001)
      begin
        step_cnt_d  = step_reload;
        step_tick_d = 1'b1;
      end
      else
        step_cnt_d = step_cnt_q - 11'h001;
    end
  end

  // PWM timebase registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      unit_cnt_q  <= {UNIT_W{1'b0}};
      unit_tick_q <= 1'b0;
      step_cnt_q  <= 11'h001;
      step_tick_q <= 1'b0;
    end
    else
    begin
      unit_cnt_q  <= unit_cnt_d;
      unit_tick_q <= unit_tick_d;
      step_cnt_q  <= step_cnt_d;
      step_tick_q <= step_tick_d;
    end
  end

  // divisor is a power of two
  assign div_last = 7'((8'h01 << ctrl_q[`FPT_CTRL_TDIV_MSB:`FPT_CTRL_TDIV_LSB]) - 8'h01);

  // tach clock of 30.52 us units
  always_comb
  begin
    base_cnt_d  = base_cnt_q + {{(BASE_W-1){1'b0}}, 1'b1};
    div_cnt_d   = div_cnt_q;
    tach_tick_d = 1'b0;
    if (base_cnt_q == BASE_W'(TACH_BASE_CYC - 1))
    begin
      base_cnt_d = {BASE_W{1'b0}};
      // A smaller divisor written mid-count restarts at once rather than wrapping
      if (div_cnt_q >= div_last)
      begin
        div_cnt_d   = 7'h00;
        tach_tick_d = 1'b1;
      end
      else
        div_cnt_d = div_cnt_q + 7'h01;
    end
  end

  // Tach timebase registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      base_cnt_q  <= {BASE_W{1'b0}};
      div_cnt_q   <= 7'h00;
      tach_tick_q <= 1'b0;
    end
    else
    begin
      base_cnt_q  <= base_cnt_d;
      div_cnt_q   <= div_cnt_d;
      tach_tick_q <= tach_tick_d;
    end
  end

  // Pin synchroniser; the level moves only when the last two stages agree
  always_comb
  begin
    sync_d     = {sync_q[1:0], fan_tach_in};
    tach_lvl_d = tach_lvl_q;
    if (sync_q[1] == sync_q[2])
      tach_lvl_d = sync_q[2];
  end

  // Synchroniser registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_q     <= 3'h0;
      tach_lvl_q <= 1'b0;
    end
    else
    begin
      sync_q     <= sync_d;
      tach_lvl_q <= tach_lvl_d;
    end
  end

  fpt_pwm u_pwm (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .step_tick (step_tick_q),
    .duty      (duty_q[`FPT_DUTY_MSB:`FPT_DUTY_LSB]),
    .override  (duty_q[`FPT_DUTY_OVR_BIT]),
    .pwm_q     (pwm_level)
  );

  assign fan_pwm_output = pwm_level;

  fpt_tach #(
    .CNT_W (8)
  ) u_tach (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .tach_tick  (tach_tick_q),
    .tach_level (tach_lvl_q),
    .count_q    (tach_count),
    .valid_q    (tach_valid)
  );

endmodule

`default_nettype wire

/* fpt_cfg.svh */
// Offsets, field positions, reset values and timing counts of the fan PWM and tach block
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH

// System clock period in picoseconds (200 MHz)
`define FPT_CLK_PERIOD_PS     5000

// Register offsets on the plain register port
`define FPT_ADDR_W            2
`define FPT_OFF_DUTY          2'h0
`define FPT_OFF_CTRL          2'h1
`define FPT_OFF_TACH          2'h2
`define FPT_OFF_STAT          2'h3

// Fan duty register fields
`define FPT_DUTY_OVR_BIT      0
`define FPT_DUTY_LSB          1
`define FPT_DUTY_MSB          6
`define FPT_DUTY_RANGE_BIT    7
`define FPT_DUTY_RST          8'h01

// Fan control register fields
`define FPT_CTRL_TDIV_LSB     0
`define FPT_CTRL_TDIV_MSB     2
`define FPT_CTRL_PRESC_LSB    3
`define FPT_CTRL_PRESC_MSB    7
`define FPT_CTRL_RST          8'h00

// Status register fields
`define FPT_STAT_PWM_BIT      0
`define FPT_STAT_VALID_BIT    1

// Shortest PWM high time (0.00033 ms) and the cycles of one duty step, rounded up
`define FPT_PWM_HIGH_MIN_NS   330
`define FPT_PWM_UNIT_CYC      ((`FPT_PWM_HIGH_MIN_NS * 1000 + `FPT_CLK_PERIOD_PS - 1) / `FPT_CLK_PERIOD_PS)
// Step length multiplier applied to a nonzero prescale
`define FPT_PWM_PRESC_MULT    19

// Tach timebase of 30.52 us per divisor unit, in cycles
`define FPT_TACH_BASE_NS      30520
`define FPT_TACH_BASE_CYC     ((`FPT_TACH_BASE_NS * 1000) / `FPT_CLK_PERIOD_PS)

// Least tach high phase, in tach clock periods, for a pulse to count
`define FPT_TACH_HIGH_MIN     3

`endif

/* fpt_pkg.sv */
// Types shared by the fan PWM and tach block
package fpt_pkg;

  typedef logic [7:0] fpt_byte_t;

  // Tach pulse qualifier states
  typedef enum logic [1:0] {
    FPT_TACH_WAIT,
    FPT_TACH_LOW,
    FPT_TACH_HIGH
  } fpt_tach_state_t;

endpackage

/* fpt_pwm.sv */
// Six-bit PWM waveform generator for the fan output
`include "fpt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fpt_pwm (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       step_tick,
  input  wire logic [5:0] duty,
  input  wire logic       override,
  output logic            pwm_q
);

  logic [5:0] phase_q;
  logic [5:0] phase_d;
  logic [5:0] duty_q;
  logic [5:0] duty_d;
  logic       pwm_d;

  // Phase walks 64 steps; new duty is taken only at the period start so a write never leaves a runt pulse
  always_comb
  begin
    phase_d = phase_q;
    duty_d  = duty_q;
    if (step_tick)
    begin
      phase_d = phase_q + 6'h01;
      if (phase_q == 6'h3F)
        duty_d = duty;
    end
    if (override)
      pwm_d = 1'b1;
    else if (duty_q == 6'h00)
      pwm_d = 1'b0;
    else
      pwm_d = (phase_q < duty_q);
  end

  // Phase, held duty and output
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_q <= 6'h00;
      duty_q  <= 6'h00;
      pwm_q   <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      duty_q  <= duty_d;
      pwm_q   <= pwm_d;
    end
  end

endmodule

`default_nettype wire

/* fpt_tach.sv */
// Tach pulse qualifier and period counter
`include "fpt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fpt_tach #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             tach_tick,
  input  wire logic             tach_level,
  output logic [CNT_W-1:0]      count_q,
  output logic                  valid_q
);

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  fpt_pkg::fpt_tach_state_t state_q;
  fpt_pkg::fpt_tach_state_t state_d;
  logic [1:0]               high_q;
  logic [1:0]               high_d;
  logic [CNT_W-1:0]         run_q;
  logic [CNT_W-1:0]         run_d;
  logic                     armed_q;
  logic                     armed_d;
  logic [CNT_W-1:0]         count_d;
  logic                     valid_d;
  logic                     qual_edge;

  // Sampled once per tach clock; pulses with a short high phase are treated as noise
  always_comb
  begin
    state_d   = state_q;
    high_d    = high_q;
    run_d     = run_q;
    armed_d   = armed_q;
    count_d   = count_q;
    valid_d   = valid_q;
    qual_edge = 1'b0;
    if (tach_tick)
    begin
      if (run_q != CNT_MAX)
        run_d = run_q + {{(CNT_W-1){1'b0}}, 1'b1};
      case (state_q)
        fpt_pkg::FPT_TACH_WAIT:
        begin
          if (!tach_level)
            state_d = fpt_pkg::FPT_TACH_LOW;
        end
        fpt_pkg::FPT_TACH_LOW:
        begin
          if (tach_level)
          begin
            state_d = fpt_pkg::FPT_TACH_HIGH;
            high_d  = 2'h1;
          end
        end
        fpt_pkg::FPT_TACH_HIGH:
        begin
          if (tach_level)
          begin
            if (high_q != 2'h3)
              high_d = high_q + 2'h1;
          end
          else
          begin
            state_d   = fpt_pkg::FPT_TACH_LOW;
            qual_edge = (high_q >= 2'(`FPT_TACH_HIGH_MIN));
          end
        end
        default:
          state_d = fpt_pkg::FPT_TACH_WAIT;
      endcase
      if (qual_edge)
      begin
        armed_d = 1'b1;
        // The tick that sees the edge closes the last period, so it is counted too
        if (armed_q)
        begin
          count_d = run_d;
          valid_d = 1'b1;
        end
        run_d   = {CNT_W{1'b0}};
      end
      // A stopped fan shows as a saturated count
      else if (armed_q && run_q == CNT_MAX)
      begin
        count_d = CNT_MAX;
        valid_d = 1'b1;
      end
    end
  end

  // Qualifier and count registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= fpt_pkg::FPT_TACH_WAIT;
      high_q  <= 2'h0;
      run_q   <= {CNT_W{1'b0}};
      armed_q <= 1'b0;
      count_q <= {CNT_W{1'b0}};
      valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      high_q  <= high_d;
      run_q   <= run_d;
      armed_q <= armed_d;
      count_q <= count_d;
      valid_q <= valid_d;
    end
  end

endmodule

`default_nettype wire

/* fpt_top_sva.sv */
// Port-level assertion checker for the fan PWM and tach block
`include "fpt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fpt_top_sva #(
  parameter int unsigned TACH_BASE_CYC = 8,
  parameter int unsigned PWM_UNIT_CYC  = 2
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic [`FPT_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   fan_tach_in,
  input wire logic                   fan_pwm_output
);
  logic [7:0]  duty_q;
  logic [7:0]  ctrl_q;
  logic [15:0] age_q;
  logic [15:0] run_q;
  logic        pwm_q;
  logic [2:0]  ovr_q;
  logic        settled;
  // Shadows of software writes; the checker never looks inside the design
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      duty_q <= 8'h01;
      ctrl_q <= 8'h00;
      age_q  <= 16'h0000;
      run_q  <= 16'h0000;
      pwm_q  <= 1'b0;
      ovr_q  <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 2'h0) duty_q <= reg_wdata;
      if (reg_wr && reg_addr == 2'h1) ctrl_q <= reg_wdata;
      age_q <= (reg_wr && !reg_addr[1]) ? 16'h0000 : ((age_q == 16'hFFFF) ? age_q : age_q + 16'h0001);
      run_q <= (fan_pwm_output != pwm_q) ? 16'h0001 : run_q + 16'h0001;
      pwm_q <= fan_pwm_output;
      ovr_q <= !duty_q[0] ? 3'h0 : ((ovr_q == 3'h7) ? ovr_q : ovr_q + 3'h1);
    end
  end
  // Two full periods since the last setting change, prescale zero, so runs are exact
  assign settled = (age_q > 16'(130 * PWM_UNIT_CYC)) && !duty_q[7] && (ctrl_q[7:3] == 5'h00);

  chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero outside its slot");
  chk_reg_readback: assert property (@(posedge sys_clk) disable iff (rst)
    $past(reg_rd) && !$past(reg_addr[1]) |-> reg_rdata == ($past(reg_addr[0]) ? $past(ctrl_q) : $past(duty_q)))
    else $error("register read back differs from last write");
  chk_status_pwm: assert property (@(posedge sys_clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == 2'h3 && $past(fan_pwm_output) == $past(fan_pwm_output, 2)
    |-> reg_rdata[0] == $past(fan_pwm_output)) else $error("status level bit differs from fan output");
  chk_ovr_fast: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == 2'h0 && reg_wdata[0] |-> ##2 fan_pwm_output) else $error("override slow to act");
  chk_ovr_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ovr_q >= 3'h3 |-> fan_pwm_output) else $error("output low while override set");
  chk_zero_low: assert property (@(posedge sys_clk) disable iff (rst)
    settled && duty_q[6:0] == 7'h00 |-> !fan_pwm_output) else $error("output high with zero duty");
  chk_high_run: assert property (@(posedge sys_clk) disable iff (rst)
    settled && !duty_q[0] && pwm_q && !fan_pwm_output |-> run_q == 16'(duty_q[6:1] * PWM_UNIT_CYC))
    else $error("high time wrong for duty");
  chk_low_run: assert property (@(posedge sys_clk) disable iff (rst)
    settled && !duty_q[0] && !pwm_q && fan_pwm_output |-> run_q == 16'((64 - duty_q[6:1]) * PWM_UNIT_CYC))
    else $error("low time wrong for duty");
endmodule
bind fpt_top fpt_top_sva #(.TACH_BASE_CYC(TACH_BASE_CYC), .PWM_UNIT_CYC(PWM_UNIT_CYC)) fpt_top_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_tach_in(fan_tach_in), .fan_pwm_output(fan_pwm_output));
`default_nettype wire

/* fpt_fan_model.sv */
// Behavioural cooling fan returning tach pulses
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_model (
  input  wire logic        sys_clk,
  input  wire logic        spin,
  input  wire logic [15:0] high_cyc,
  input  wire logic [15:0] low_cyc,
  output logic             tach_q = 1'b1
);
  logic [15:0] cnt_q = 16'h0000;
  always_ff @(posedge sys_clk)
  begin
    if (!spin)
    begin
      tach_q <= 1'b1; // Stopped rotor leaves the pulled-up line high
      cnt_q  <= 16'h0000;
    end
    else
    begin
      tach_q <= (cnt_q < high_cyc);
      cnt_q  <= (cnt_q >= high_cyc + low_cyc - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the fan PWM and tach block
`include "fpt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned UNIT = 2;
  logic                   sys_clk;
  logic                   rst;
  logic                   reg_wr;
  logic                   reg_rd;
  logic                   fan_tach_in;
  logic                   fan_pwm_output;
  logic                   spin;
  logic [`FPT_ADDR_W-1:0] reg_addr;
  logic [7:0]             reg_wdata;
  logic [7:0]             reg_rdata;
  logic [7:0]             v;
  logic [15:0]            high_cyc;
  logic [15:0]            low_cyc;
  logic [15:0]            hv;
  int                     miscompares = 0;
  int                     comparisons = 0;
  int                     duties[4] = '{0, 1, 32, 63};

  fpt_top #(.TACH_BASE_CYC(8), .PWM_UNIT_CYC(UNIT)) fpt_top_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_tach_in(fan_tach_in), .fan_pwm_output(fan_pwm_output));
  fpt_fan_model fpt_fan_model_inst (
    .sys_clk(sys_clk), .spin(spin), .high_cyc(high_cyc), .low_cyc(low_cyc), .tach_q(fan_tach_in));

  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Data is taken in the one cycle after the strobe edge
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic highs(input int n, output logic [15:0] h);
    h = 16'h0000;
    repeat (n)
    begin
      @(posedge sys_clk);
      #1 if (fan_pwm_output === 1'b1) h = h + 16'h0001;
    end
  endtask

  // Wait two periods so the new duty is latched, then count high cycles over one
  task automatic pwm_case(input logic [7:0] c, input logic [7:0] d, input int per, input logic [15:0] exp);
    logic [15:0] h;
    wr(2'h1, c);
    wr(2'h0, d);
    rd(2'h0, v);
    check(v, d);
    repeat (2 * per + 8) @(posedge sys_clk);
    highs(per, h);
    check(h, exp);
  endtask

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 13600 cycles
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR at %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    rst = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    spin = 1'b0;
    high_cyc = 16'h0060;
    low_cyc = 16'h0020;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(2'h0, v);
    check(v, 8'h01);
    rd(2'h1, v);
    check(v, 8'h00);
    $display("reset test done");
    wr(2'h0, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 check(fan_pwm_output, 1'b0);
    wr(2'h0, 8'h41);
    highs(256, hv);
    check(hv, 16'h0100);
    $display("override test done");
    foreach (duties[i])
      pwm_case(8'h00, 8'(duties[i] * 2), 64 * UNIT, 16'(duties[i] * UNIT));
    pwm_case(8'h08, 8'h40, 64 * UNIT * 19, 16'(32 * UNIT * 19));
    $display("duty test done");
    wr(2'h1, 8'h00);
    spin <= 1'b1;
    repeat (600) @(posedge sys_clk);
    rd(2'h2, v);
    check(v, 8'h10);
    rd(2'h3, v);
    check(v[1], 1'b1);
    wr(2'h1, 8'h01);
    repeat (800) @(posedge sys_clk);
    rd(2'h2, v);
    check(v, 8'h08);
    wr(2'h2, 8'h55);
    rd(2'h2, v);
    check(v, 8'h08);
    $display("tach test done");
    wr(2'h1, 8'h00);
    high_cyc <= 16'h0010;
    low_cyc <= 16'h0070;
    repeat (3000) @(posedge sys_clk);
    rd(2'h2, v);
    check(v, 8'hFF);
    $display("short pulse test done");
    close_out();
  end
endmodule
`default_nettype wire
